// [design/fsrm_consts.vh]
/*
  Constants for the floppy status, reset and mode control block.
  Assumes it is included by bare name from the design files.
*/
// What this block does
// - Bit 6: wrong kind of data mark seen
// - Bit 5: data field checksum failed
// - Bit 4: identifier track differs from internal
// - Bit 1: track mismatch and identifier equals FF
// - Bit 0: no data mark of either kind
// - Unused status bits read as zero
// - Drive status bits 5 and 3 read one
// - Drive status shows live drive lines
// - Three reset sources, all leave power-down
// - Pin reset aborts work and idles
// - Leaving reset clears settings, starts polling
// - Pin reset spares specify values
// - Pin reset sets control reset bit
// - Software resets clear core and FIFO
// - Rate reset self-clears; control reset dominates
// - Mode chosen by option bits 3 and 2
// - First mode: gated, density active high
// - Second mode: always enabled, density low
// - Third mode: gated, density active low
// - Specify enables DMA; request starts transfer
// - Single transfers unless option bit 1
// - FIFO disabled after any reset
// - Density high after pin reset only
// - Status bytes shown in result phase
`ifndef FSRM_CONSTS_VH
`define FSRM_CONSTS_VH
`define FSRM_S2_CM_BIT    6
`define FSRM_S2_DD_BIT    5
`define FSRM_S2_WT_BIT    4
`define FSRM_S2_BT_BIT    1
`define FSRM_S2_MD_BIT    0
`define FSRM_BAD_TRACK    8'hFF
`define FSRM_OCR_RST_BIT  2
`define FSRM_OCR_DMA_BIT  3
`define FSRM_OPT_BURST    1
`define FSRM_OPT_MODE_HI  3
`define FSRM_OPT_MODE_LO  2
`define FSRM_MODE_FIRST   2'h3
`define FSRM_MODE_SECOND  2'h2
`define FSRM_MODE_THIRD   2'h1
`define FSRM_SEL_S2       1'h0
`define FSRM_SEL_S3       1'h1
`endif

// [design/fsrm_reset_ctrl.v]
/*
  Reset source combiner for the controller core.
  Assumes register writes are one-cycle strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsrm_consts.vh"
module fsrm_reset_ctrl
(
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Register writes
  input  wire ocr_wr_i,
  input  wire ocr_rst_i,
  input  wire rate_wr_i,
  input  wire rate_rst_i,
  // Reset state
  output wire ocr_rst_o,
  output wire core_rst_o,
  output wire leave_rst_o
);
  reg ocr_rst_r;
  reg rate_rst_r;
  reg core_rst_d_r;
  // Control bit holds until written clear; set by pin reset
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ocr_rst_r    <= 1'b1;
      rate_rst_r   <= 1'b0;
      core_rst_d_r <= 1'b1;
    end
    else
    begin
      if (ocr_wr_i)
        ocr_rst_r <= ocr_rst_i;
      rate_rst_r   <= rate_wr_i && rate_rst_i;
      core_rst_d_r <= core_rst_o;
    end
  end
  // Any source resets the core
  assign core_rst_o  = ocr_rst_r || rate_rst_r;
  assign ocr_rst_o   = ocr_rst_r;
  assign leave_rst_o = core_rst_d_r && !core_rst_o;
endmodule
`default_nettype wire

// [design/fsrm_sector_status.v]
/*
  Sector error status byte collector.
  Assumes event strobes are one-cycle pulses from the core sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsrm_consts.vh"
module fsrm_sector_status
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clr_i,
  // Events
  input  wire       cmd_start_i,
  input  wire       mark_seen_i,
  input  wire       mark_deleted_i,
  input  wire       read_deleted_i,
  input  wire       crc_fail_i,
  input  wire       id_seen_i,
  input  wire [7:0] id_track_i,
  input  wire [7:0] cur_track_i,
  input  wire       mark_missing_i,
  // Status byte
  output wire [7:0] status_o
);
  reg cm_r;
  reg dd_r;
  reg wt_r;
  reg bt_r;
  reg md_r;
  wire mism = id_seen_i && (id_track_i != cur_track_i);
  // Sticky flags, cleared at new command; an event in that cycle wins
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cm_r <= 1'b0;
      dd_r <= 1'b0;
      wt_r <= 1'b0;
      bt_r <= 1'b0;
      md_r <= 1'b0;
    end
    else
    begin
      cm_r <= (mark_seen_i && (mark_deleted_i != read_deleted_i)) ||
              (cm_r && !(clr_i || cmd_start_i));
      dd_r <= crc_fail_i || (dd_r && !(clr_i || cmd_start_i));
      wt_r <= mism || (wt_r && !(clr_i || cmd_start_i));
      bt_r <= (mism && id_track_i == `FSRM_BAD_TRACK) ||
              (bt_r && !(clr_i || cmd_start_i));
      md_r <= mark_missing_i || (md_r && !(clr_i || cmd_start_i));
    end
  end
  // Unused bits tied low
  assign status_o = {1'b0, cm_r, dd_r, wt_r, 2'b00, bt_r, md_r};
endmodule
`default_nettype wire

// [design/fsrm_top.v]
/*
  Floppy status, reset and interface mode control.
  Assumes synchronous drive lines and one-cycle command strobes from
  the core sequencer; host writes arrive as byte strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsrm_consts.vh"
module fsrm_top
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Host register writes
  input  wire       ocr_wr_i,
  input  wire [7:0] ocr_wdata_i,
  input  wire       rate_wr_i,
  input  wire       rate_rst_bit_i,
  input  wire [7:0] option_cfg_i,
  // Command sequencer strobes
  input  wire       cmd_start_i,
  input  wire       specify_wr_i,
  input  wire       specify_dma_i,
  input  wire       configure_wr_i,
  input  wire       configure_fifo_en_i,
  input  wire       configure_poll_en_i,
  input  wire       result_rd_i,
  input  wire       result_sel_i,
  input  wire       hi_density_i,
  input  wire       xfer_req_i,
  input  wire       core_irq_i,
  // Sector events
  input  wire       mark_seen_i,
  input  wire       mark_deleted_i,
  input  wire       read_deleted_i,
  input  wire       crc_fail_i,
  input  wire       id_seen_i,
  input  wire [7:0] id_track_i,
  input  wire [7:0] cur_track_i,
  input  wire       mark_missing_i,
  // Drive lines
  input  wire       write_protect_i,
  input  wire       track_zero_input_i,
  input  wire       head_select_output_i,
  input  wire [1:0] drive_select_output_i,
  // Outputs
  output reg  [7:0] result_data_o,
  output wire       core_rst_o,
  output wire       power_down_exit_o,
  output reg        fifo_en_o,
  output reg        poll_en_o,
  output reg        dma_mode_o,
  output wire       burst_o,
  output wire       dma_req_o,
  output wire       irq_o,
  output reg        density_select_output_o,
  output wire [1:0] mode_o
);
  wire [7:0] s2;
  wire       leave_rst;
  wire       dma_gate;
  reg        ocr_dma_r;
  reg        density_nxt;

  fsrm_sector_status u_s2
  (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .clr_i          (core_rst_o),
    .cmd_start_i    (cmd_start_i),
    .mark_seen_i    (mark_seen_i),
    .mark_deleted_i (mark_deleted_i),
    .read_deleted_i (read_deleted_i),
    .crc_fail_i     (crc_fail_i),
    .id_seen_i      (id_seen_i),
    .id_track_i     (id_track_i),
    .cur_track_i    (cur_track_i),
    .mark_missing_i (mark_missing_i),
    .status_o       (s2)
  );

  fsrm_reset_ctrl u_rst
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ocr_wr_i    (ocr_wr_i),
    .ocr_rst_i   (ocr_wdata_i[`FSRM_OCR_RST_BIT]),
    .rate_wr_i   (rate_wr_i),
    .rate_rst_i  (rate_rst_bit_i),
    .ocr_rst_o   (),
    .core_rst_o  (core_rst_o),
    .leave_rst_o (leave_rst)
  );

  // Any reset source wakes the core
  assign power_down_exit_o = rst_i || core_rst_o;
  assign mode_o  = option_cfg_i[`FSRM_OPT_MODE_HI:`FSRM_OPT_MODE_LO];
  assign burst_o = option_cfg_i[`FSRM_OPT_BURST];

  // Gate from control register DMA bit, ignored in second mode
  assign dma_gate = (mode_o == `FSRM_MODE_SECOND) ? 1'b1 : ocr_dma_r;
  assign dma_req_o = dma_mode_o && dma_gate && xfer_req_i && !core_rst_o;
  assign irq_o     = dma_gate && core_irq_i && !core_rst_o;

  // Control register DMA enable; pin reset only
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ocr_dma_r <= 1'b0;
    else if (ocr_wr_i)
      ocr_dma_r <= ocr_wdata_i[`FSRM_OCR_DMA_BIT];
  end

  // Specify values survive pin reset; only the command changes them
  always @(posedge clk_i)
  begin
    if (specify_wr_i)
      dma_mode_o <= specify_dma_i;
  end

  // Configure settings: cleared by any reset, polling restarts on exit
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fifo_en_o <= 1'b0;
      poll_en_o <= 1'b0;
    end
    else if (core_rst_o)
    begin
      fifo_en_o <= 1'b0;
      poll_en_o <= 1'b0;
    end
    else if (leave_rst)
    begin
      fifo_en_o <= 1'b0;
      poll_en_o <= 1'b1;
    end
    else if (configure_wr_i)
    begin
      fifo_en_o <= configure_fifo_en_i;
      poll_en_o <= configure_poll_en_i;
    end
  end

  // Density polarity by mode
  always @*
  begin
    density_nxt = hi_density_i;
    if (mode_o != `FSRM_MODE_FIRST)
      density_nxt = !hi_density_i;
  end

  // Density held through software resets
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      density_select_output_o <= 1'b1;
    else if (!core_rst_o)
      density_select_output_o <= density_nxt;
  end

  // Result byte for the data register
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      result_data_o <= 8'h00;
    else if (result_rd_i)
    begin
      if (result_sel_i == `FSRM_SEL_S2)
        result_data_o <= s2;
      else
        result_data_o <= {1'b0, write_protect_i, 1'b1, track_zero_input_i,
                          1'b1, head_select_output_i,
                          drive_select_output_i};
    end
  end
endmodule
`default_nettype wire

// [verif/fsrm_host_model.sv]
/* Host processor model: writes to control and rate registers.
   Assumes tasks are entered just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module fsrm_host_model
(
  // Clock
  input  wire logic       clk_i,
  // Register writes
  output var  logic       ocr_wr_o,
  output var  logic       rate_wr_o,
  output var  logic       rate_rst_o,
  output var  logic [7:0] ocr_wdata_o
);
  initial {ocr_wr_o, rate_wr_o, rate_rst_o, ocr_wdata_o} = 11'h000;
  // One-cycle write; the released data bus shows the inverse
  task wr_ocr(input logic [7:0] d);
    ocr_wdata_o = d;
    ocr_wr_o = 1'h1;
    @(posedge clk_i) #1;
    ocr_wr_o = 1'h0;
    ocr_wdata_o = ~d;
  endtask
  // Rate reset strobe; the bit clears itself in the device
  task wr_rate;
    rate_rst_o = 1'h1;
    rate_wr_o = 1'h1;
    @(posedge clk_i) #1;
    rate_wr_o = 1'h0;
    rate_rst_o = 1'h0;
  endtask
endmodule
`default_nettype wire

// [verif/fsrm_top_monitor.sv]
/* Port-level checker for fsrm_top.
   Assumes one clock and the async pin reset; bound to every fsrm_top. */
`timescale 1ns/100ps
`default_nettype none
module fsrm_top_monitor
(
  // Watched ports
  input wire logic       clk_i, rst_i, ocr_wr_i, rate_wr_i, rate_rst_bit_i, hi_density_i,
  input wire logic       core_irq_i, result_rd_i, result_sel_i, write_protect_i, core_rst_o,
  input wire logic       power_down_exit_o, fifo_en_o, poll_en_o, burst_o, irq_o,
  input wire logic       density_select_output_o,
  input wire logic [7:0] ocr_wdata_i, option_cfg_i, result_data_o,
  input wire logic [1:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Control reset bit written high, then the strobe drops
  sequence s_ocr_set;
    ocr_wr_i && ocr_wdata_i[2] ##1 !ocr_wr_i;
  endsequence
  // Host clears the control reset bit while the core is held
  sequence s_exit;
    core_rst_o && ocr_wr_i && !ocr_wdata_i[2] && !rate_wr_i;
  endsequence
  a_mode_map: assert property (mode_o == option_cfg_i[3:2])
    else $error("mode does not follow option bits");
  a_burst_sel: assert property (burst_o == option_cfg_i[1])
    else $error("burst does not follow option bit");
  a_pdown_exit: assert property (core_rst_o |-> power_down_exit_o)
    else $error("core reset left power-down untouched");
  a_rate_reset: assert property (rate_wr_i && rate_rst_bit_i |-> ##[0:1] core_rst_o)
    else $error("rate reset did not reach core");
  a_ocr_hold: assert property (s_ocr_set |-> core_rst_o)
    else $error("control reset bit not holding core");
  a_leave_reset: assert property (s_exit |=> !core_rst_o ##1 poll_en_o)
    else $error("core did not leave reset with polling");
  a_fifo_clear: assert property (core_rst_o |=> !fifo_en_o)
    else $error("fifo enabled after reset");
  a_s2_unused: assert property (result_rd_i && !result_sel_i |=>
    result_data_o[7] == 1'h0 && result_data_o[3:2] == 2'h0) else $error("sector status spare bits");
  a_s3_lines: assert property (result_rd_i && result_sel_i |=> result_data_o[3] &&
    result_data_o[7:5] == {1'h0, $past(write_protect_i), 1'h1}) else $error("drive status bits");
  a_density_pol: assert property (!core_rst_o |=> density_select_output_o ==
    ($past(mode_o) == 2'h3 ? $past(hi_density_i) : !$past(hi_density_i)))
    else $error("density polarity wrong");
  a_irq_open: assert property (!core_rst_o && mode_o == 2'h2 |-> irq_o == core_irq_i)
    else $error("interrupt gated in second mode");
endmodule
bind fsrm_top fsrm_top_monitor i_fsrm_top_monitor (.*);
`default_nettype wire

// [verif/fsrm_top_tb_top.sv]
/* Self-checking bench for fsrm_top.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module fsrm_top_tb_top;
  logic clk_i, rst_i = 1'h1, cmd_start_i = 1'h0, specify_wr_i = 1'h0, specify_dma_i = 1'h0;
  logic configure_wr_i = 1'h0, configure_fifo_en_i = 1'h0, configure_poll_en_i = 1'h0;
  logic result_rd_i = 1'h0, result_sel_i = 1'h0, hi_density_i = 1'h0, xfer_req_i = 1'h0;
  logic core_irq_i = 1'h0, mark_seen_i = 1'h0, mark_deleted_i = 1'h0, read_deleted_i = 1'h0;
  logic crc_fail_i = 1'h0, id_seen_i = 1'h0, mark_missing_i = 1'h0, write_protect_i = 1'h0;
  logic track_zero_input_i = 1'h0, head_select_output_i = 1'h0;
  logic [1:0] drive_select_output_i = 2'h0;
  logic [7:0] option_cfg_i = 8'h0C, id_track_i = 8'h00, cur_track_i = 8'h05;
  wire ocr_wr_i, rate_wr_i, rate_rst_bit_i, core_rst_o, power_down_exit_o, fifo_en_o;
  wire poll_en_o, dma_mode_o, burst_o, dma_req_o, irq_o, density_select_output_o;
  wire [7:0] ocr_wdata_i, result_data_o;
  wire [1:0] mode_o;
  int n_mismatch = 0, check_count = 0;
  fsrm_top i_fsrm_top (.*);
  fsrm_host_model i_fsrm_host_model (.clk_i(clk_i), .ocr_wr_o(ocr_wr_i), .rate_wr_o(rate_wr_i),
    .rate_rst_o(rate_rst_bit_i), .ocr_wdata_o(ocr_wdata_i));
  // Clock
  initial
  begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  task cyc(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task rd(input logic s, input logic [7:0] exp);
    result_sel_i = s;
    result_rd_i = 1'h1;
    cyc;
    result_rd_i = 1'h0;
    chk("status byte", exp, result_data_o);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Pin reset, then the host releases the core
  task t_pin_reset;
    rst_i = 1'h1;
    cyc(5);
    rst_i = 1'h0;
    cyc;
    chk("core_rst", 8'h01, core_rst_o);
    chk("pdown_exit", 8'h01, power_down_exit_o);
    chk("density", 8'h01, density_select_output_o);
    chk("fifo_en", 8'h00, fifo_en_o);
    i_fsrm_host_model.wr_ocr(8'h00);
    chk("core_rst", 8'h00, core_rst_o);
    cyc;
    chk("poll_en", 8'h01, poll_en_o);
  endtask
  // Each event except the missing mark lands with the clearing strobe, which it must beat
  task t_sector;
    cmd_start_i = 1'h1;
    crc_fail_i = 1'h1;
    cyc;
    crc_fail_i = 1'h0;
    rd(1'h0, 8'h20);
    id_track_i = 8'hFF;
    id_seen_i = 1'h1;
    cyc;
    rd(1'h0, 8'h12);
    id_track_i = 8'h07;
    cyc;
    id_seen_i = 1'h0;
    rd(1'h0, 8'h10);
    mark_seen_i = 1'h1;
    mark_deleted_i = 1'h1;
    cyc;
    cmd_start_i = 1'h0;
    mark_seen_i = 1'h0;
    mark_missing_i = 1'h1;
    cyc;
    mark_missing_i = 1'h0;
    rd(1'h0, 8'h41);
    cmd_start_i = 1'h1;
    mark_seen_i = 1'h1;
    mark_deleted_i = 1'h0;
    read_deleted_i = 1'h1;
    id_track_i = 8'h05;
    id_seen_i = 1'h1;
    cyc;
    {cmd_start_i, mark_seen_i, read_deleted_i, id_seen_i} = 4'h0;
    rd(1'h0, 8'h40);
  endtask
  task t_drive;
    {write_protect_i, track_zero_input_i, head_select_output_i} = 3'h5;
    drive_select_output_i = 2'h2;
    rd(1'h1, 8'h6E);
    {write_protect_i, track_zero_input_i, head_select_output_i} = 3'h2;
    drive_select_output_i = 2'h1;
    rd(1'h1, 8'h39);
  endtask
  task t_modes;
    int m;
    specify_wr_i = 1'h1;
    specify_dma_i = 1'h1;
    cyc;
    specify_wr_i = 1'h0;
    chk("dma_mode", 8'h01, dma_mode_o);
    {hi_density_i, core_irq_i, xfer_req_i} = 3'h7;
    for (m = 3; m > 0; m--)
    begin
      option_cfg_i = {4'h0, m[1:0], m[0], 1'h0};
      cyc(2);
      chk("mode", m[7:0], mode_o);
      chk("burst", {7'h00, m[0]}, burst_o);
      chk("density", {7'h00, m == 3}, density_select_output_o);
      chk("irq", {7'h00, m == 2}, irq_o);
      chk("dma_req", {7'h00, m == 2}, dma_req_o);
    end
    i_fsrm_host_model.wr_ocr(8'h08);
    cyc;
    chk("irq", 8'h01, irq_o);
    chk("dma_req", 8'h01, dma_req_o);
  endtask
  // Software resets, both together, then rate reset alone
  task t_swrst;
    {configure_wr_i, configure_fifo_en_i, crc_fail_i, hi_density_i} = 4'hE;
    option_cfg_i = 8'h0C;
    cyc(2);
    {configure_wr_i, crc_fail_i} = 2'h0;
    chk("fifo_en", 8'h01, fifo_en_o);
    i_fsrm_host_model.wr_ocr(8'h0C);
    hi_density_i = 1'h1;
    i_fsrm_host_model.wr_rate;
    cyc(2);
    chk("core_rst", 8'h01, core_rst_o);
    chk("density", 8'h00, density_select_output_o);
    chk("fifo_en", 8'h00, fifo_en_o);
    i_fsrm_host_model.wr_ocr(8'h08);
    rd(1'h0, 8'h00);
    configure_wr_i = 1'h1;
    cyc;
    configure_wr_i = 1'h0;
    i_fsrm_host_model.wr_rate;
    cyc(2);
    chk("core_rst", 8'h00, core_rst_o);
    chk("fifo_en", 8'h00, fifo_en_o);
  endtask
  // Main sequence
  initial
  begin
    t_pin_reset;
    t_sector;
    t_drive;
    t_modes;
    t_swrst;
    t_pin_reset;
    chk("dma_mode", 8'h01, dma_mode_o);
    end_of_test;
  end
  // Hang guard
  initial
  begin
    cyc(5000);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
